// File: core/cfg_regs_pkg.sv
// Constants for the serial configuration register bank
package cfg_regs_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SWING = 8'h01;
  localparam logic [7:0] ADDR_PERF_C = 8'h02;
  localparam logic [7:0] ADDR_PERF_A = 8'h03;
  localparam logic [7:0] ADDR_GAIN_A = 8'h25;
  localparam logic [7:0] ADDR_FORMAT = 8'h29;
  localparam logic [7:0] ADDR_GAIN_B = 8'h2b;
  localparam logic [7:0] ADDR_OFS_EN = 8'h3d;
  localparam logic [7:0] ADDR_PAT_HI = 8'h3f;
  localparam logic [7:0] ADDR_PAT_LO = 8'h40;
  localparam logic [7:0] ADDR_PORT_SEL = 8'h41;
  localparam logic [7:0] ADDR_CLK_SHIFT = 8'h42;
  localparam logic [7:0] ADDR_DRIVE = 8'h45;
  localparam logic [7:0] ADDR_HF_B = 8'h4a;
  localparam logic [7:0] ADDR_HF_A = 8'h58;
  localparam logic [7:0] ADDR_OFS_A = 8'hbf;
  localparam logic [7:0] ADDR_OFS_B = 8'hc1;
  localparam logic [7:0] ADDR_OFS_CTL = 8'hcf;
  localparam logic [7:0] ADDR_PERF_D = 8'hd5;
  localparam logic [7:0] ADDR_PERF_E = 8'hd7;
  localparam logic [7:0] ADDR_PERF_F = 8'hdb;
  localparam logic [7:0] ADDR_SLOW_EN = 8'hef;
  localparam logic [7:0] ADDR_SWING_EN = 8'hf1;
  localparam logic [7:0] ADDR_SLOW_A = 8'hf2;
  // Field positions
  localparam int BIT_READBACK = 0;
  localparam int BIT_SOFT_RST = 1;
  localparam int SWING_LSB = 2;
  localparam int GAIN_LSB = 4;
  // Reset value of every register
  localparam logic [7:0] REG_RESET = 8'h00;
  // Frame layout
  localparam int FRAME_BITS = 16;
  // Swing codes
  localparam logic [5:0] SWING_DEFAULT = 6'h00;
  localparam logic [5:0] SWING_410 = 6'h1b;
  localparam logic [5:0] SWING_465 = 6'h32;
  localparam logic [5:0] SWING_570 = 6'h14;
  localparam logic [5:0] SWING_200 = 6'h3e;
  localparam logic [5:0] SWING_125 = 6'h0f;
  // Performance codes
  localparam logic [1:0] PERF_DEFAULT = 2'h0;
  localparam logic [1:0] PERF_BEST = 2'h3;
  // Highest defined gain code
  localparam logic [3:0] GAIN_MAX = 4'hc;
  // Pattern select codes
  localparam logic [2:0] PAT_NORMAL = 3'h0;
  localparam logic [2:0] PAT_ZEROS = 3'h1;
  localparam logic [2:0] PAT_ONES = 3'h2;
  localparam logic [2:0] PAT_TOGGLE = 3'h3;
  localparam logic [2:0] PAT_RAMP = 3'h4;
  localparam logic [2:0] PAT_USER = 3'h5;
  // Minimum hardware reset pulse, ns, and cycles at 4 ns (rounded up)
  localparam int HW_RST_MIN_NS = 10;
  localparam int CLK_PERIOD_NS = 4;
  localparam int HW_RST_CYC = (HW_RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// File: core/serial_cfg_bank.sv
// Serial configuration register bank with readback and decoded fields
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - One frame updates all fields of register
// - Every register reads zero after reset
// - Soft reset bit clears all, self-clears
// - Read pin undriven unless readback enabled
// - Decode six-bit swing code to levels
// - Performance field: 00 default, 11 best
// - Channel A gain in half-dB steps
// - Sixteen falling edges commit address, data
// - Readback blocks writes, shifts data out
// - Long high reset pin pulse clears registers
// - Pattern select picks test output source
module serial_cfg_bank (
  input wire logic MCLK_I, // System clock, 250 MHz
  input wire logic ARST_N_I, // Async reset, active low
  input wire logic HW_RST_I, // Reset pin, active high
  input wire logic SERIAL_SELECT_LINE_N_I, // Frame select, active low
  input wire logic SCLK_I, // Serial clock pin
  input wire logic SERIAL_INPUT_LINE_I, // Serial data in
  output logic SERIAL_READ_OUT_PIN_O, // Readback data out
  output logic SERIAL_READ_OUT_PIN_OE_O, // Readback drive enable
  output logic [2:0] SWING_LEVEL_O, // Decoded swing, 0 default
  output logic SWING_VALID_O, // Swing code is a defined one
  output logic PERF_BEST_O, // Best performance selected
  output logic [4:0] GAIN_A_HALF_DB_O, // Channel A gain, 0.5 dB units
  output logic [2:0] PATTERN_A_SRC_O, // Channel A output source
  output logic [2:0] PATTERN_B_SRC_O, // Channel B output source
  output logic [13:0] USER_PATTERN_O // User test pattern
);

  // Synchronisers for pin inputs
  logic [1:0] sen_s_q, sclk_s_q, sdi_s_q, hrst_s_q;
  logic sclk_prev_q; // Last synchronised clock level
  logic [15:0] shift_q; // Incoming frame bits
  logic [3:0] bit_cnt_q; // Bits taken in current frame
  logic [7:0] regs_q [0:23]; // Register storage
  logic [7:0] rd_shift_q; // Readback shifter
  logic [2:0] hrst_cnt_q; // Reset pin high duration
  logic soft_rst_q; // Soft reset pending for one cycle

  // Synchronise all pins through two stages
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      sen_s_q <= 2'h3;
      sclk_s_q <= 2'h0;
      sdi_s_q <= 2'h0;
      hrst_s_q <= 2'h0;
    end else begin
      sen_s_q <= {sen_s_q[0], SERIAL_SELECT_LINE_N_I};
      sclk_s_q <= {sclk_s_q[0], SCLK_I};
      sdi_s_q <= {sdi_s_q[0], SERIAL_INPUT_LINE_I};
      hrst_s_q <= {hrst_s_q[0], HW_RST_I};
    end
  end

  // Address to index decode; unmapped gives valid low
  function automatic logic [5:0] addr_index(input logic [7:0] a);
    unique case (a)
      cfg_regs_pkg::ADDR_CTRL: addr_index = 6'h20;
      cfg_regs_pkg::ADDR_SWING: addr_index = 6'h21;
      cfg_regs_pkg::ADDR_PERF_C: addr_index = 6'h22;
      cfg_regs_pkg::ADDR_PERF_A: addr_index = 6'h23;
      cfg_regs_pkg::ADDR_GAIN_A: addr_index = 6'h24;
      cfg_regs_pkg::ADDR_FORMAT: addr_index = 6'h25;
      cfg_regs_pkg::ADDR_GAIN_B: addr_index = 6'h26;
      cfg_regs_pkg::ADDR_OFS_EN: addr_index = 6'h27;
      cfg_regs_pkg::ADDR_PAT_HI: addr_index = 6'h28;
      cfg_regs_pkg::ADDR_PAT_LO: addr_index = 6'h29;
      cfg_regs_pkg::ADDR_PORT_SEL: addr_index = 6'h2a;
      cfg_regs_pkg::ADDR_CLK_SHIFT: addr_index = 6'h2b;
      cfg_regs_pkg::ADDR_DRIVE: addr_index = 6'h2c;
      cfg_regs_pkg::ADDR_HF_B: addr_index = 6'h2d;
      cfg_regs_pkg::ADDR_HF_A: addr_index = 6'h2e;
      cfg_regs_pkg::ADDR_OFS_A: addr_index = 6'h2f;
      cfg_regs_pkg::ADDR_OFS_B: addr_index = 6'h30;
      cfg_regs_pkg::ADDR_OFS_CTL: addr_index = 6'h31;
      cfg_regs_pkg::ADDR_PERF_D: addr_index = 6'h32;
      cfg_regs_pkg::ADDR_PERF_E: addr_index = 6'h33;
      cfg_regs_pkg::ADDR_PERF_F: addr_index = 6'h34;
      cfg_regs_pkg::ADDR_SLOW_EN: addr_index = 6'h35;
      cfg_regs_pkg::ADDR_SWING_EN: addr_index = 6'h36;
      cfg_regs_pkg::ADDR_SLOW_A: addr_index = 6'h37;
      default: addr_index = 6'h00;
    endcase
  endfunction

  // Frame decode
  wire sen_act = ~sen_s_q[1]; // Select asserted
  wire sclk_fall = sclk_prev_q & ~sclk_s_q[1]; // Falling serial edge
  wire take_bit = sen_act & sclk_fall;
  wire [15:0] frame_nxt = {shift_q[14:0], sdi_s_q[1]}; // Frame with new bit
  wire frame_done = take_bit & (bit_cnt_q == 4'hf); // 16th edge
  wire addr_done = take_bit & (bit_cnt_q == 4'h7); // Address complete
  wire [5:0] wr_idx = addr_index(frame_nxt[15:8]); // Target of write
  wire [5:0] rd_idx = addr_index(frame_nxt[7:0]); // Target of read
  wire readback_on = regs_q[0][cfg_regs_pkg::BIT_READBACK]; // Readback mode
  wire wr_en = frame_done & wr_idx[5] & ~readback_on;
  // Clears on the third synchronised high cycle, the shortest pulse counted
  wire hrst_hit = hrst_s_q[1] & (hrst_cnt_q >= 3'(cfg_regs_pkg::HW_RST_CYC - 1));
  wire clear_all = soft_rst_q | hrst_hit; // Return to defaults

  // Serial clock edge tracker and bit counter; excess bits are
  // dropped because only whole 16-bit frames ever commit
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      sclk_prev_q <= 1'b0;
      bit_cnt_q <= 4'h0;
      shift_q <= 16'h0000;
    end else begin
      sclk_prev_q <= sclk_s_q[1];
      if (!sen_act) begin
        bit_cnt_q <= 4'h0; // Frame boundary realigns
      end else if (take_bit) begin
        bit_cnt_q <= bit_cnt_q + 4'h1;
        shift_q <= frame_nxt;
      end
    end
  end

  // Hardware reset pulse width measurement
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      hrst_cnt_q <= 3'h0;
    end else if (!hrst_s_q[1]) begin
      hrst_cnt_q <= 3'h0;
    end else if (!hrst_hit) begin
      hrst_cnt_q <= hrst_cnt_q + 3'h1;
    end
  end

  // Soft reset is a one-cycle pulse; the stored bit never holds a one
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= wr_en & (wr_idx[4:0] == 5'h00) &
                    frame_nxt[cfg_regs_pkg::BIT_SOFT_RST];
    end
  end

  // Register storage; whole byte written at once
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      for (int i = 0; i < 24; i++) begin
        regs_q[i] <= cfg_regs_pkg::REG_RESET;
      end
    end else if (clear_all) begin
      for (int i = 0; i < 24; i++) begin
        regs_q[i] <= cfg_regs_pkg::REG_RESET;
      end
    end else if (wr_en) begin
      regs_q[wr_idx[4:0]] <= frame_nxt[7:0] &
        ((wr_idx[4:0] == 5'h00) ? 8'hfd : 8'hff);
    end
  end

  // Readback: address byte picks register, bits leave MSB first
  // one per falling edge so the host samples before the next fall
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      rd_shift_q <= 8'h00;
      SERIAL_READ_OUT_PIN_O <= 1'b0;
    end else if (addr_done) begin
      rd_shift_q <= rd_idx[5] ? regs_q[rd_idx[4:0]] : 8'h00;
      SERIAL_READ_OUT_PIN_O <= 1'b0;
    end else if (take_bit && bit_cnt_q[3]) begin
      SERIAL_READ_OUT_PIN_O <= rd_shift_q[7];
      rd_shift_q <= {rd_shift_q[6:0], 1'b0};
    end
  end

  // Output drive follows readback bit
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      SERIAL_READ_OUT_PIN_OE_O <= 1'b0;
    end else begin
      SERIAL_READ_OUT_PIN_OE_O <= readback_on;
    end
  end

  // Field decodes
  wire [5:0] swing_code = regs_q[1][7:cfg_regs_pkg::SWING_LSB]; // Swing field
  logic [2:0] swing_lvl; // Decoded level index
  logic swing_ok; // Code is defined
  always_comb begin
    swing_ok = 1'b1;
    unique case (swing_code)
      cfg_regs_pkg::SWING_DEFAULT: swing_lvl = 3'h0;
      cfg_regs_pkg::SWING_410: swing_lvl = 3'h1;
      cfg_regs_pkg::SWING_465: swing_lvl = 3'h2;
      cfg_regs_pkg::SWING_570: swing_lvl = 3'h3;
      cfg_regs_pkg::SWING_200: swing_lvl = 3'h4;
      cfg_regs_pkg::SWING_125: swing_lvl = 3'h5;
      default: begin
        swing_lvl = 3'h0; // Undefined code keeps default swing
        swing_ok = 1'b0;
      end
    endcase
  end
  // Swing applies only with override on; ADDR_SWING_EN bits 1:0 gate it
  wire swing_ovr = |regs_q[22][1:0];
  wire [1:0] perf_field = regs_q[3][1:0]; // Performance field
  wire [3:0] gain_code = regs_q[4][7:cfg_regs_pkg::GAIN_LSB]; // Gain code
  // Reserved gain codes saturate at 6 dB
  wire [4:0] gain_half_db = (gain_code > cfg_regs_pkg::GAIN_MAX) ?
                            {1'b0, cfg_regs_pkg::GAIN_MAX} : {1'b0, gain_code};

  // Pattern code check; unused codes fall back to normal data
  function automatic logic [2:0] pat_sel(input logic [2:0] c);
    pat_sel = (c > cfg_regs_pkg::PAT_USER) ? cfg_regs_pkg::PAT_NORMAL : c;
  endfunction

  // Registered field outputs
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      SWING_LEVEL_O <= 3'h0;
      SWING_VALID_O <= 1'b1;
      PERF_BEST_O <= 1'b0;
      GAIN_A_HALF_DB_O <= 5'h00;
      PATTERN_A_SRC_O <= 3'h0;
      PATTERN_B_SRC_O <= 3'h0;
      USER_PATTERN_O <= 14'h0000;
    end else begin
      SWING_LEVEL_O <= swing_ovr ? swing_lvl : 3'h0;
      SWING_VALID_O <= swing_ok;
      PERF_BEST_O <= (perf_field == cfg_regs_pkg::PERF_BEST);
      GAIN_A_HALF_DB_O <= gain_half_db;
      PATTERN_A_SRC_O <= pat_sel(regs_q[4][2:0]);
      PATTERN_B_SRC_O <= pat_sel(regs_q[6][2:0]);
      USER_PATTERN_O <= {regs_q[8][5:0], regs_q[9]};
    end
  end

  // Assertions
  property p_oe_follows;
    @(posedge MCLK_I) disable iff (!ARST_N_I)
      readback_on |=> SERIAL_READ_OUT_PIN_OE_O;
  endproperty
  a_oe_follows: assert property (p_oe_follows) else $error("oe not on");

  property p_oe_off;
    @(posedge MCLK_I) disable iff (!ARST_N_I)
      !readback_on ##1 !readback_on |-> !SERIAL_READ_OUT_PIN_OE_O;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("oe on in write mode");

  property p_soft_clears;
    @(posedge MCLK_I) disable iff (!ARST_N_I)
      soft_rst_q |=> (regs_q[4] == 8'h00) && (regs_q[0] == 8'h00);
  endproperty
  a_soft_clears: assert property (p_soft_clears) else $error("soft reset");

  property p_softbit_low;
    @(posedge MCLK_I) disable iff (!ARST_N_I)
      !regs_q[0][cfg_regs_pkg::BIT_SOFT_RST];
  endproperty
  a_softbit_low: assert property (p_softbit_low) else $error("self clear");

  property p_ro_block;
    @(posedge MCLK_I) disable iff (!ARST_N_I)
      frame_done && readback_on && !clear_all |=> $stable(regs_q[4]);
  endproperty
  a_ro_block: assert property (p_ro_block) else $error("write in readback");

  property p_commit;
    @(posedge MCLK_I) disable iff (!ARST_N_I)
      wr_en && !clear_all && frame_nxt[15:8] == cfg_regs_pkg::ADDR_GAIN_A
        |=> regs_q[4] == $past(frame_nxt[7:0]);
  endproperty
  a_commit: assert property (p_commit) else $error("frame lost");

  property p_hw_rst;
    @(posedge MCLK_I) disable iff (!ARST_N_I)
      hrst_s_q[1] [*3] |=> regs_q[1] == 8'h00;
  endproperty
  a_hw_rst: assert property (p_hw_rst) else $error("pin reset");

  property p_gain;
    @(posedge MCLK_I) disable iff (!ARST_N_I)
      gain_code <= cfg_regs_pkg::GAIN_MAX |=> GAIN_A_HALF_DB_O == {1'b0, $past(gain_code)};
  endproperty
  a_gain: assert property (p_gain) else $error("gain decode");

  property p_perf;
    @(posedge MCLK_I) disable iff (!ARST_N_I)
      perf_field == cfg_regs_pkg::PERF_DEFAULT |=> !PERF_BEST_O;
  endproperty
  a_perf: assert property (p_perf) else $error("perf decode");

  property p_cnt;
    @(posedge MCLK_I) disable iff (!ARST_N_I)
      frame_done |=> bit_cnt_q == 4'h0;
  endproperty
  a_cnt: assert property (p_cnt) else $error("frame count");

  property p_unmapped;
    @(posedge MCLK_I) disable iff (!ARST_N_I)
      frame_done && !wr_idx[5] && !clear_all |=> $stable(regs_q[0]) && $stable(regs_q[1]);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped write landed");

  property p_rd_zero;
    @(posedge MCLK_I) disable iff (!ARST_N_I)
      addr_done && !rd_idx[5] |=> (rd_shift_q == 8'h00) && !SERIAL_READ_OUT_PIN_O;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("unmapped read not zero");

  property p_rd_shift;
    @(posedge MCLK_I) disable iff (!ARST_N_I)
      take_bit && bit_cnt_q[3] |=> SERIAL_READ_OUT_PIN_O == $past(rd_shift_q[7]);
  endproperty
  a_rd_shift: assert property (p_rd_shift) else $error("readback bit order");

  property p_rb_stays;
    @(posedge MCLK_I) disable iff (!ARST_N_I)
      readback_on && !clear_all |=> readback_on;
  endproperty
  a_rb_stays: assert property (p_rb_stays) else $error("readback left by write");

  property p_swing_dec;
    @(posedge MCLK_I) disable iff (!ARST_N_I)
      swing_ovr && (swing_code == cfg_regs_pkg::SWING_125) |=> SWING_LEVEL_O == 3'h5;
  endproperty
  a_swing_dec: assert property (p_swing_dec) else $error("swing decode");

  property p_pat_b;
    @(posedge MCLK_I) disable iff (!ARST_N_I)
      regs_q[6][2:0] == cfg_regs_pkg::PAT_TOGGLE |=> PATTERN_B_SRC_O == cfg_regs_pkg::PAT_TOGGLE;
  endproperty
  a_pat_b: assert property (p_pat_b) else $error("pattern decode");

  property p_bit_hold;
    @(posedge MCLK_I) disable iff (!ARST_N_I)
      sen_act && !take_bit |=> $stable(bit_cnt_q);
  endproperty
  a_bit_hold: assert property (p_bit_hold) else $error("bit count moved");

endmodule
`default_nettype wire

// File: dv/cfg_host_model.sv
// Host-side model of the four-wire serial configuration port
`timescale 1ns/1ps
`default_nettype none
module cfg_host_model (
  output logic sclk_o, // Serial clock, still low between frames
  output logic sel_n_o, // Frame select, active low
  output logic data_o, // Serial data toward the device
  input wire logic rd_pad_i // Resolved level of the read pin
);
  localparam time HALF = 40; // Half of the 80 ns link period
  // Idle state: clock still, select released
  initial begin
    sclk_o = 1'b0;
    sel_n_o = 1'b1;
    data_o = 1'b0;
  end
  // Sends the low n bits of w MSB first inside one select pulse
  // Bits seen on the read pin after falls 9..16 come back in rd
  task automatic frame(input logic [31:0] w, input int n, output logic [7:0] rd);
    rd = 8'h00;
    // Offset keeps link edges away from the system clock edges
    #1.3;
    sel_n_o = 1'b0;
    #HALF;
    for (int i = 0; i < n; i++) begin
      sclk_o = 1'b1;
      data_o = w[n-1-i]; // Changed mid-period, stable across the fall
      #HALF;
      sclk_o = 1'b0; // Falling edge strobes the bit
      #HALF;
      // Latched before the next strobe, a full half period after the fall
      if (i >= 8 && i < 16) begin
        rd[15-i] = rd_pad_i;
      end
    end
    sel_n_o = 1'b1;
    data_o = ~data_o; // Released line shows no stale value
    #(2*HALF);
  endtask
endmodule
`default_nettype wire

// File: dv/serial_cfg_bank_tb.sv
// Self-checking bench for the serial configuration register bank
`timescale 1ns/1ps
`default_nettype none
module serial_cfg_bank_tb;
  logic mclk; // System clock
  logic arst_n; // Async reset, active low
  logic hw_rst; // Reset pin, active high
  wire logic sclk; // Link clock from the host
  wire logic sel_n; // Frame select from the host
  wire logic serial_input_line; // Serial data from the host
  logic rd_out; // Read pin data
  logic rd_oe; // Read pin drive enable
  wire logic rd_pad; // Read pin level, floats when undriven
  logic [2:0] swing_lvl; // Decoded swing
  logic swing_ok; // Swing code defined
  logic perf_best; // Best performance flag
  logic [4:0] gain_a; // Channel A gain
  logic [2:0] pat_a; // Channel A source
  logic [2:0] pat_b; // Channel B source
  logic [13:0] user_pat; // User pattern
  logic [7:0] rd; // Read data from the host
  int num_errors = 0; // Mismatches seen
  int total_checks = 0; // Comparisons made
  int cycles = 0; // Cycle count for the hang limit
  localparam logic [5:0] SW_CODES [6] = '{cfg_regs_pkg::SWING_DEFAULT,
    cfg_regs_pkg::SWING_410, cfg_regs_pkg::SWING_465, cfg_regs_pkg::SWING_570,
    cfg_regs_pkg::SWING_200, cfg_regs_pkg::SWING_125}; // In level order

  assign rd_pad = rd_oe ? rd_out : 1'bz;

  serial_cfg_bank uut (
    .MCLK_I(mclk), .ARST_N_I(arst_n), .HW_RST_I(hw_rst), .SERIAL_SELECT_LINE_N_I(sel_n),
    .SCLK_I(sclk), .SERIAL_INPUT_LINE_I(serial_input_line), .SERIAL_READ_OUT_PIN_O(rd_out),
    .SERIAL_READ_OUT_PIN_OE_O(rd_oe), .SWING_LEVEL_O(swing_lvl), .SWING_VALID_O(swing_ok),
    .PERF_BEST_O(perf_best), .GAIN_A_HALF_DB_O(gain_a), .PATTERN_A_SRC_O(pat_a),
    .PATTERN_B_SRC_O(pat_b), .USER_PATTERN_O(user_pat)
  );

  cfg_host_model host (.sclk_o(sclk), .sel_n_o(sel_n), .data_o(serial_input_line), .rd_pad_i(rd_pad));

  // 250 MHz system clock
  initial mclk = 1'b0;
  always #2 mclk = ~mclk;

  // Hang limit, well above the roughly 18k cycles the tests need
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      give_verdict();
    end
  end

  // Compares one value and reports a mismatch
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One full write frame, then time for the outputs to settle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] unused;
    host.frame({16'h0000, a, d}, 16, unused);
    repeat (4) @(negedge mclk);
  endtask

  // One read frame and a compare of the returned byte
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    host.frame({16'h0000, a, 8'h00}, 16, rd);
    check("read_data", {8'h00, rd}, {8'h00, exp});
  endtask

  // All outputs but the read pin data at their cleared values
  task automatic check_idle();
    check("swing_level", 16'(swing_lvl), 16'h0000);
    check("swing_valid", 16'(swing_ok), 16'h0001);
    check("perf_best", 16'(perf_best), 16'h0000);
    check("gain_a", 16'(gain_a), 16'h0000);
    check("pattern_a", 16'(pat_a), 16'h0000);
    check("pattern_b", 16'(pat_b), 16'h0000);
    check("user_pattern", 16'(user_pat), 16'h0000);
    check("read_oe", 16'(rd_oe), 16'h0000);
  endtask

  // Verdict and end of run
  task automatic give_verdict();
    if (num_errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    arst_n = 1'b0;
    hw_rst = 1'b0; // Pin held low during serial use
    repeat (2) @(negedge mclk);
    arst_n = 1'b1;
    repeat (4) @(negedge mclk);
    check_idle();
    // Swing codes, override enabled first and fixed bits kept zero
    wr(cfg_regs_pkg::ADDR_SWING_EN, 8'h01);
    for (int k = 0; k < 6; k++) begin
      wr(cfg_regs_pkg::ADDR_SWING, {SW_CODES[k], 2'b00});
      check("swing_level", 16'(swing_lvl), 16'(k));
      check("swing_valid", 16'(swing_ok), 16'h0001);
    end
    wr(cfg_regs_pkg::ADDR_SWING, 8'h04);
    check("swing_valid", 16'(swing_ok), 16'h0000);
    // Performance field, only the two legal codes
    wr(cfg_regs_pkg::ADDR_PERF_A, 8'h03);
    check("perf_best", 16'(perf_best), 16'h0001);
    wr(cfg_regs_pkg::ADDR_PERF_A, 8'h00);
    check("perf_best", 16'(perf_best), 16'h0000);
    // Every defined gain code, gain and pattern in one write
    for (int g = 0; g <= 12; g++) begin
      wr(cfg_regs_pkg::ADDR_GAIN_A, {4'(g), 1'b0, 3'(g % 6)});
      wr(cfg_regs_pkg::ADDR_GAIN_B, {4'h0, 1'b0, 3'(5 - g % 6)});
      check("gain_a", 16'(gain_a), 16'(g));
      check("pattern_a", 16'(pat_a), 16'(g % 6));
      check("pattern_b", 16'(pat_b), 16'(5 - g % 6));
    end
    wr(cfg_regs_pkg::ADDR_PAT_HI, 8'h2a);
    wr(cfg_regs_pkg::ADDR_PAT_LO, 8'h5c);
    check("user_pattern", 16'(user_pat), 16'({6'h2a, 8'h5c}));
    // Two frames in one select pulse
    host.frame({cfg_regs_pkg::ADDR_GAIN_A, 8'h55, cfg_regs_pkg::ADDR_GAIN_B, 8'h23}, 32, rd);
    repeat (4) @(negedge mclk);
    check("gain_a", 16'(gain_a), 16'h0005);
    check("pattern_b", 16'(pat_b), 16'h0003);
    // Four excess bits, then a dropped partial frame
    host.frame({12'h000, cfg_regs_pkg::ADDR_PAT_HI, 8'h15, 4'hf}, 20, rd);
    host.frame({22'h000000, cfg_regs_pkg::ADDR_PAT_HI[7:6]}, 2, rd);
    wr(cfg_regs_pkg::ADDR_PAT_LO, 8'h00);
    check("user_pattern", 16'(user_pat), 16'({6'h15, 8'h00}));
    // Unmapped address leaves everything alone
    wr(8'h26, 8'hff);
    check("user_pattern", 16'(user_pat), 16'({6'h15, 8'h00}));
    // Soft reset clears the whole bank
    wr(cfg_regs_pkg::ADDR_CTRL, 8'h02);
    check_idle();
    // Readback mode: pin driven, data out, writes blocked
    wr(cfg_regs_pkg::ADDR_GAIN_A, 8'ha3);
    wr(cfg_regs_pkg::ADDR_CTRL, 8'h01);
    check("read_oe", 16'(rd_oe), 16'h0001);
    rd_reg(cfg_regs_pkg::ADDR_GAIN_A, 8'ha3);
    rd_reg(8'h26, 8'h00);
    rd_reg(cfg_regs_pkg::ADDR_CTRL, 8'h01);
    wr(cfg_regs_pkg::ADDR_GAIN_A, 8'h11);
    check("gain_a", 16'(gain_a), 16'h000a);
    rd_reg(cfg_regs_pkg::ADDR_GAIN_A, 8'ha3);
    // Reset pin pulse of three cycles, the shortest one that must clear
    hw_rst = 1'b1;
    repeat (3) @(negedge mclk);
    hw_rst = 1'b0;
    repeat (8) @(negedge mclk);
    check_idle();
    give_verdict();
  end
endmodule
`default_nettype wire
